// [pfl_defs.svh]
// Command codes, field positions, reset values and coefficients
`ifndef PFL_DEFS_SVH
`define PFL_DEFS_SVH
// Command codes
`define PFL_CMD_PAGE 8'h00
`define PFL_CMD_POWER 8'h01
`define PFL_CMD_CLRFLT 8'h03
`define PFL_CMD_UPMARGIN 8'h25
`define PFL_CMD_VSTAT 8'h80
`define PFL_CMD_VOUTRD 8'h8b
`define PFL_CMD_MODE 8'hd1
`define PFL_CMD_KEY 8'hd3
`define PFL_CMD_REACT 8'hd5
`define PFL_CMD_IPEAK 8'hd7
`define PFL_CMD_TPEAK 8'hd8
// Mode control fields and reset value
`define PFL_MODE_ALERT 0
`define PFL_MODE_LOCK 1
`define PFL_MODE_RST 8'h01
// Vendor status lock flag position
`define PFL_VSTAT_LOCK 7
// Power command on bit
`define PFL_PWR_ON 7
// Reaction config fields, two bits per fault type
`define PFL_RC_OV 0
`define PFL_RC_OC 2
`define PFL_RC_OT 4
`define PFL_RC_UV 6
`define PFL_RC_PIN 8
`define PFL_RC_W 9
`define PFL_RESP_LATCH 2'b01
`define PFL_RESP_RETRY 2'b10
// Status bit positions per channel
`define PFL_ST_OV 0
`define PFL_ST_OC 1
`define PFL_ST_OT 2
`define PFL_ST_UV 3
// Answer byte counts and locked filler
`define PFL_LEN_NONE 2'd0
`define PFL_LEN_BYTE 2'd1
`define PFL_LEN_WORD 2'd2
`define PFL_ALL_ONES 16'hffff
`define PFL_POS_MAX 16'h7fff
// Direct-format coefficients (m, b, R) per class
`define PFL_M_VOLT 1
`define PFL_R_VOLT 0
`define PFL_M_CURR 1
`define PFL_R_CURR 2
`define PFL_M_TEMP 1
`define PFL_R_TEMP 2
`define PFL_M_TIME 5
`define PFL_R_TIME 0
`define PFL_B_ALL 0
`endif

// [pfl_pkg.sv]
// Shared types of the fault and lock command layer
package pfl_pkg;
    // Alert line state
    typedef enum logic {AL_IDLE, AL_ASSERT} pfl_alert_t;
    // One data word in direct format
    typedef logic [15:0] pfl_word_t;
endpackage

// [pfl_fault_lock.sv]
// Fault latching, alert, pre-enable check and lock of the command layer
`timescale 1ns/1ps
`include "pfl_defs.svh"

module pfl_fault_lock #(
    parameter int NCH = 16,
    parameter logic [6:0] SLAVE_ADDR = 7'h40, // Arbitrary default address
    parameter logic LOCK_INIT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic softRst,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [31:0] cmdData,
    output logic rdValid,
    output logic [15:0] rdData,
    output logic [1:0] rdLen,
    input wire logic araReq,
    input wire logic araWon,
    output logic araAck,
    output logic [6:0] araAddr,
    output logic alertOut,
    output logic alertOe,
    input wire logic [NCH-1:0] ovFlt,
    input wire logic [NCH-1:0] ocFlt,
    input wire logic [NCH-1:0] otFlt,
    input wire logic [NCH-1:0] uvFlt,
    input wire logic [NCH*16-1:0] voutMeas,
    input wire logic [NCH*16-1:0] ioutMeas,
    input wire logic [15:0] tempMeas,
    input wire logic groupSwitchPin0,
    input wire logic [31:0] nvKey,
    output logic [NCH-1:0] supplyEn,
    output logic faultPinOut,
    output logic faultPinOe
);
    localparam int PW = (NCH > 1) ? $clog2(NCH) : 1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] page; // Selected channel
        logic [7:0] mode; // Vendor mode control
        logic lock; // Command access locked
        logic opOn; // Power command on request
        logic [NCH-1:0][15:0] margin; // Upper margin targets
        logic [NCH-1:0][`PFL_RC_W-1:0] cfg; // Reaction config
        logic [NCH-1:0][3:0] st; // Latched fault status
        logic [NCH-1:0] latch; // Latched off by fault
        logic [NCH-1:0] en; // Supply enables
        logic [NCH-1:0][15:0] iPk; // Peak current codes
        logic [15:0] tPk; // Peak temperature code
        pfl_pkg::pfl_alert_t al; // Alert line state
        logic rdValid;
        logic [15:0] rdData;
        logic [1:0] rdLen;
        logic araAck;
    } pfl_state_t;

    // Reset image, also used by the soft reset
    function automatic pfl_state_t pflRstVal();
        pfl_state_t v;
        v = '0;
        v.mode = `PFL_MODE_RST;
        v.lock = LOCK_INIT;
        v.al = pfl_pkg::AL_IDLE;
        return v;
    endfunction
    localparam pfl_state_t ST_RST = pflRstVal();

    pfl_state_t s_ff; // Registered state
    pfl_state_t nxt_s; // Next state

    // Response code asks for a pre-enable check
    function automatic logic pflChecked(input logic [1:0] rc);
        return (rc == `PFL_RESP_LATCH) || (rc == `PFL_RESP_RETRY);
    endfunction

    // ------------------------------------------------------------
    // Per-channel fault decode
    // ------------------------------------------------------------
    logic [NCH-1:0] chkOk; // No checked fault present
    logic [NCH-1:0] latF; // Fault with latch-off response
    logic [NCH-1:0] retF; // Fault with retry response
    logic [NCH-1:0] pinF; // Fault that drives the fault pin
    logic [NCH-1:0] evF; // Status bit newly latched per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gCh
            logic [1:0] rOv, rOc, rOt, rUv;
            logic [3:0] hit;
            assign rOv = s_ff.cfg[g][`PFL_RC_OV +: 2];
            assign rOc = s_ff.cfg[g][`PFL_RC_OC +: 2];
            assign rOt = s_ff.cfg[g][`PFL_RC_OT +: 2];
            assign rUv = s_ff.cfg[g][`PFL_RC_UV +: 2];
            // Undervoltage is only meaningful while the supply is on
            assign hit = {uvFlt[g] & s_ff.en[g], otFlt[g], ocFlt[g], ovFlt[g]};
            // Undervoltage left out of the check: supply still off
            assign chkOk[g] = !((ovFlt[g] && pflChecked(rOv)) || (ocFlt[g] && pflChecked(rOc))
                || (otFlt[g] && pflChecked(rOt)));
            // Each fault type reacts by its own code
            assign latF[g] = (hit[0] && rOv == `PFL_RESP_LATCH) || (hit[1] && rOc == `PFL_RESP_LATCH)
                || (hit[2] && rOt == `PFL_RESP_LATCH) || (hit[3] && rUv == `PFL_RESP_LATCH);
            assign retF[g] = (hit[0] && rOv == `PFL_RESP_RETRY) || (hit[1] && rOc == `PFL_RESP_RETRY)
                || (hit[2] && rOt == `PFL_RESP_RETRY) || (hit[3] && rUv == `PFL_RESP_RETRY);
            assign pinF[g] = s_ff.cfg[g][`PFL_RC_PIN] && (latF[g] || retF[g] || s_ff.latch[g]);
            assign evF[g] = |(hit & ~s_ff.st[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [PW-1:0] pg; // Page as channel index
    logic isWr; // Write command this cycle
    logic isRd; // Read command this cycle
    logic wrAllowed; // Command may be written while locked
    logic wrOk; // Write is accepted
    logic clrCond; // Clear-faults command seen
    logic onReq; // Supplies asked to be on
    logic newEv; // A status bit newly latched
    logic [15:0] vWord; // Selected voltage reading
    logic [15:0] vAbs; // Its positive magnitude
    assign pg = s_ff.page[PW-1:0];
    assign isWr = cmdValid && cmdWrite;
    assign isRd = cmdValid && !cmdWrite;
    assign wrAllowed = (cmdCode == `PFL_CMD_PAGE) || (cmdCode == `PFL_CMD_POWER)
        || (cmdCode == `PFL_CMD_CLRFLT) || (cmdCode == `PFL_CMD_KEY);
    assign wrOk = isWr && (!s_ff.lock || wrAllowed);
    assign clrCond = isWr && cmdCode == `PFL_CMD_CLRFLT;
    // Monitor keeps serving; only the enables and the latch-off follow this
    assign onReq = s_ff.opOn || groupSwitchPin0;
    assign newEv = |evF; // Taken from the inputs, not nxt_s, so no loop through the next-state process
    assign vWord = voutMeas[pg*16 +: 16];
    // Negative rails reported as magnitude; the most negative code saturates
    always_comb begin
        vAbs = vWord[15] ? 16'(~vWord + 16'h0001) : vWord;
        if (vAbs[15]) begin
            vAbs = `PFL_POS_MAX;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdValid = 1'b0;
        nxt_s.araAck = 1'b0;
        // Channel status, latch-off and enable
        for (int i = 0; i < NCH; i++) begin
            // Set wins over a simultaneous clear
            nxt_s.st[i] = (clrCond ? 4'h0 : s_ff.st[i])
                | {uvFlt[i] & s_ff.en[i], otFlt[i], ocFlt[i], ovFlt[i]};
            // Only a running supply latches off; an off one is held by the check
            nxt_s.latch[i] = (s_ff.latch[i] && onReq) || (latF[i] && s_ff.en[i]);
            // Enable only from a passed check; retry keeps checking
            nxt_s.en[i] = onReq && !nxt_s.latch[i] && !retF[i]
                && (s_ff.en[i] || chkOk[i]);
            // Peak current code, hundredths of ampere
            if ($signed(ioutMeas[i*16 +: 16]) > $signed(s_ff.iPk[i])) begin
                nxt_s.iPk[i] = ioutMeas[i*16 +: 16];
            end
        end
        // Peak temperature code, hundredths of degree
        if ($signed(tempMeas) > $signed(s_ff.tPk)) begin
            nxt_s.tPk = tempMeas;
        end
        // Alert line
        case (s_ff.al)
            pfl_pkg::AL_IDLE: begin
                if (newEv && s_ff.mode[`PFL_MODE_ALERT]) begin
                    nxt_s.al = pfl_pkg::AL_ASSERT;
                end
            end
            pfl_pkg::AL_ASSERT: begin
                // Lost arbitration keeps the line low for another try
                if (araReq && araWon) begin
                    nxt_s.araAck = 1'b1;
                    nxt_s.al = newEv ? pfl_pkg::AL_ASSERT : pfl_pkg::AL_IDLE;
                end
            end
            default: begin
                nxt_s.al = pfl_pkg::AL_IDLE;
            end
        endcase
        // Writes; data word arrives low byte first from the transport
        if (wrOk) begin
            case (cmdCode)
                `PFL_CMD_PAGE: nxt_s.page = cmdData[7:0];
                `PFL_CMD_POWER: nxt_s.opOn = cmdData[`PFL_PWR_ON];
                `PFL_CMD_UPMARGIN: nxt_s.margin[pg] = cmdData[15:0];
                `PFL_CMD_REACT: nxt_s.cfg[pg] = cmdData[`PFL_RC_W-1:0];
                `PFL_CMD_MODE: begin
                    nxt_s.mode = cmdData[7:0];
                    nxt_s.lock = cmdData[`PFL_MODE_LOCK];
                end
                `PFL_CMD_KEY: begin
                    // All four bytes of the key are compared
                    if (cmdData == nvKey) begin
                        nxt_s.lock = 1'b0;
                        nxt_s.mode[`PFL_MODE_LOCK] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Reads: locked filler keeps the normal byte count
        if (isRd) begin
            nxt_s.rdValid = 1'b1;
            nxt_s.rdLen = `PFL_LEN_WORD;
            nxt_s.rdData = `PFL_ALL_ONES;
            case (cmdCode)
                `PFL_CMD_PAGE: begin
                    nxt_s.rdLen = `PFL_LEN_BYTE;
                    nxt_s.rdData = {8'h00, s_ff.page};
                end
                `PFL_CMD_POWER: begin
                    nxt_s.rdLen = `PFL_LEN_BYTE;
                    nxt_s.rdData = {8'h00, s_ff.opOn, 7'h00};
                end
                `PFL_CMD_VSTAT: begin
                    // Always readable, locked or not
                    nxt_s.rdLen = `PFL_LEN_BYTE;
                    nxt_s.rdData = {8'h00, s_ff.lock, 3'h0, s_ff.st[pg]};
                end
                `PFL_CMD_MODE: begin
                    nxt_s.rdLen = `PFL_LEN_BYTE;
                    nxt_s.rdData = s_ff.lock ? 16'h00ff : {8'h00, s_ff.mode};
                end
                `PFL_CMD_UPMARGIN: begin
                    nxt_s.rdData = s_ff.lock ? `PFL_ALL_ONES : s_ff.margin[pg];
                end
                `PFL_CMD_VOUTRD: begin
                    nxt_s.rdData = s_ff.lock ? `PFL_ALL_ONES : vAbs;
                end
                `PFL_CMD_REACT: begin
                    nxt_s.rdData = s_ff.lock ? `PFL_ALL_ONES : 16'(s_ff.cfg[pg]);
                end
                `PFL_CMD_IPEAK: begin
                    nxt_s.rdData = s_ff.lock ? `PFL_ALL_ONES : s_ff.iPk[pg];
                end
                `PFL_CMD_TPEAK: begin
                    nxt_s.rdData = s_ff.lock ? `PFL_ALL_ONES : s_ff.tPk;
                end
                default: begin
                    // Write-only or unknown: no data bytes
                    nxt_s.rdLen = `PFL_LEN_NONE;
                end
            endcase
        end
        // Soft reset behaves as the reset pin
        if (softRst) begin
            nxt_s = ST_RST;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdValid = s_ff.rdValid;
    assign rdData = s_ff.rdData;
    assign rdLen = s_ff.rdLen;
    assign araAck = s_ff.araAck;
    assign araAddr = SLAVE_ADDR;
    // Open drain: drive low only
    assign alertOut = 1'b0;
    assign alertOe = (s_ff.al == pfl_pkg::AL_ASSERT);
    assign supplyEn = s_ff.en;
    assign faultPinOut = 1'b0;
    assign faultPinOe = |pinF;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_lockRead;
        @(posedge clk_sys) disable iff (sys_rst)
        (isRd && cmdCode == `PFL_CMD_UPMARGIN && s_ff.lock && !softRst)
        |=> (rdValid && rdData == `PFL_ALL_ONES && rdLen == `PFL_LEN_WORD);
    endproperty
    a_lockRead: assert property (p_lockRead) else $error("locked read not all ones");

    property p_lockWrite;
        @(posedge clk_sys) disable iff (sys_rst)
        (isWr && cmdCode == `PFL_CMD_UPMARGIN && s_ff.lock && !softRst) |=> $stable(s_ff.margin);
    endproperty
    a_lockWrite: assert property (p_lockWrite) else $error("locked write took effect");

    property p_unlock;
        @(posedge clk_sys) disable iff (sys_rst)
        (isWr && cmdCode == `PFL_CMD_KEY && cmdData == nvKey) |=> !s_ff.lock ##1 !s_ff.lock [*1];
    endproperty
    a_unlock: assert property (p_unlock) else $error("key match did not unlock");

    property p_alert;
        @(posedge clk_sys) disable iff (sys_rst)
        (newEv && s_ff.mode[`PFL_MODE_ALERT] && !softRst) |=> alertOe;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not driven on fault");

    property p_ara;
        @(posedge clk_sys) disable iff (sys_rst)
        (alertOe && araReq && araWon && !newEv && !softRst) |=> (araAck && !alertOe);
    endproperty
    a_ara: assert property (p_ara) else $error("alert response mishandled");

    property p_stHold;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_ff.st[0][`PFL_ST_OV] && !clrCond && !softRst) |=> s_ff.st[0][`PFL_ST_OV];
    endproperty
    a_stHold: assert property (p_stHold) else $error("status bit lost without clear");

    property p_preEn;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(s_ff.en[0]) |-> $past(chkOk[0]);
    endproperty
    a_preEn: assert property (p_preEn) else $error("channel enabled with checked fault");

    property p_latchOff;
        @(posedge clk_sys) disable iff (sys_rst)
        s_ff.latch[0] |-> (!supplyEn[0] && $past(onReq || latF[0]));
    endproperty
    a_latchOff: assert property (p_latchOff) else $error("latched channel enabled");

    property p_vPos;
        @(posedge clk_sys) disable iff (sys_rst)
        (isRd && cmdCode == `PFL_CMD_VOUTRD && !s_ff.lock && !softRst) |=> (rdValid && !rdData[15]);
    endproperty
    a_vPos: assert property (p_vPos) else $error("voltage reading not positive");

endmodule // pfl_fault_lock

// [pfl_host_model.sv]
// Host controller model that issues commands and alert responses to the command layer
`timescale 1ns/1ps

module pfl_host_model (
    input wire logic clk_sys,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [31:0] cmdData,
    input wire logic rdValid,
    input wire logic [15:0] rdData,
    input wire logic [1:0] rdLen,
    output logic araReq,
    output logic araWon,
    input wire logic araAck
);
    // ----------------------------------------
    // Request timing
    // ----------------------------------------
    int idleGap = 0; // Extra idle cycles before each command request, to mimic a slow host

    // Quiet bus at time zero
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdData = 32'h0000_0000;
        araReq = 1'b0;
        araWon = 1'b0;
    end

    // Real value to transmitted code: (m*x+b)*10^r
    function automatic logic [15:0] toDirect(input int m, input int b, input int r, input int x);
        int y;
        y = m * x + b;
        repeat (r) y = y * 10;
        return y[15:0];
    endfunction

    // One request held for one full cycle; released code and data lines show the inverse, not stale data
    task automatic issue(input logic wr, input logic [7:0] code, input logic [31:0] data);
        repeat (idleGap + 1) @(negedge clk_sys);
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdCode = code;
        cmdData = data; // First bus byte sits in [7:0], low byte first
        @(negedge clk_sys);
        cmdValid = 1'b0;
        cmdCode = ~code;
        cmdData = ~data;
    endtask

    // Read: the answer is registered and stands in the cycle after the request
    task automatic readCmd(input logic [7:0] code, output logic v, output logic [15:0] d, output logic [1:0] n);
        issue(1'b0, code, 32'h0000_0000);
        v = rdValid;
        d = rdData;
        n = rdLen;
    endtask

    // Alert response address; the host decides who wins arbitration
    task automatic araCycle(input logic won, output logic ack);
        @(negedge clk_sys);
        araReq = 1'b1;
        araWon = won;
        @(negedge clk_sys);
        araReq = 1'b0;
        araWon = ~won;
        ack = araAck;
    endtask
endmodule // pfl_host_model

// [tb_pmbus_fault_lock_layer.sv]
// Self-checking testbench of the fault and lock command layer
`timescale 1ns/1ps
`include "pfl_defs.svh"

module tb_pmbus_fault_lock_layer;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys, sys_rst, softRst, groupSwitchPin0; // Clock, resets, group switch
    logic cmdValid, cmdWrite, rdValid, araReq, araWon, araAck, alertOut, alertOe, faultPinOut, faultPinOe;
    logic [7:0] cmdCode;
    logic [31:0] cmdData, nvKey;
    logic [15:0] rdData, tempMeas;
    logic [1:0] rdLen, ovFlt, ocFlt, otFlt, uvFlt, supplyEn; // Two channels keep runs short
    logic [6:0] araAddr;
    logic [31:0] voutMeas, ioutMeas;
    logic v, ack;
    logic [15:0] d;
    logic [1:0] n;
    int nMismatch = 0;
    int totalChecks = 0;
    typedef struct {logic wr; logic [7:0] code; logic [31:0] data; logic [1:0] len; logic [15:0] exp;} pfl_row_t;
    pfl_row_t rows [7];

    pfl_fault_lock #(.NCH(2), .SLAVE_ADDR(7'h40), .LOCK_INIT(1'b0)) pfl_fault_lock_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .softRst(softRst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData), .rdLen(rdLen), .araReq(araReq), .araWon(araWon),
        .araAck(araAck), .araAddr(araAddr), .alertOut(alertOut), .alertOe(alertOe), .ovFlt(ovFlt), .ocFlt(ocFlt),
        .otFlt(otFlt), .uvFlt(uvFlt), .voutMeas(voutMeas), .ioutMeas(ioutMeas), .tempMeas(tempMeas),
        .groupSwitchPin0(groupSwitchPin0), .nvKey(nvKey), .supplyEn(supplyEn), .faultPinOut(faultPinOut),
        .faultPinOe(faultPinOe));

    pfl_host_model pfl_host_model_i (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData), .rdLen(rdLen),
        .araReq(araReq), .araWon(araWon), .araAck(araAck));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    // Case inequality so an unknown never passes
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read and compare validity, length and word together
    task automatic rdChk(input string what, input logic [7:0] code, input logic [1:0] len, input logic [15:0] exp);
        pfl_host_model_i.readCmd(code, v, d, n);
        chk({what, " valid"}, 32'h1, {31'h0, v});
        chk({what, " len"}, {30'h0, len}, {30'h0, n});
        chk({what, " data"}, {16'h0, exp}, {16'h0, d});
    endtask

    // Bounded wait for channel 0 enable to reach a level
    task automatic waitEn(input logic lvl);
        int i;
        for (i = 0; i < 10 && supplyEn[0] !== lvl; i++) @(negedge clk_sys);
        chk("supply enable wait", {31'h0, lvl}, {31'h0, supplyEn[0]});
        if (supplyEn[0] !== lvl) giveVerdict();
    endtask

    // Single closing point of the run
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        softRst = 1'b0;
        groupSwitchPin0 = 1'b0;
        {ovFlt, ocFlt, otFlt, uvFlt} = 8'h00;
        voutMeas = {16'h0100, 16'hf277}; // Channel 0 sits at -3465 mV
        ioutMeas = {16'h0200, pfl_host_model_i.toDirect(`PFL_M_CURR, `PFL_B_ALL, `PFL_R_CURR, 12)};
        tempMeas = pfl_host_model_i.toDirect(`PFL_M_TEMP, `PFL_B_ALL, `PFL_R_TEMP, 45);
        nvKey = 32'h5a3c_96e1; // Arbitrary key value
        repeat (8) @(negedge clk_sys);
        chk("alert in reset", 32'h0, {31'h0, alertOe});
        chk("enables in reset", 32'h0, {30'h0, supplyEn});
        chk("ara address", 32'h40, {25'h0, araAddr});
        sys_rst = 1'b0;
        // Ordinary cases: table of request and expected answer
        rows[0] = '{1'b1, `PFL_CMD_UPMARGIN, 32'h0000_0d89, `PFL_LEN_NONE, 16'h0};
        rows[1] = '{1'b0, `PFL_CMD_UPMARGIN, 32'h0, `PFL_LEN_WORD, 16'h0d89};
        rows[2] = '{1'b0, `PFL_CMD_VOUTRD, 32'h0, `PFL_LEN_WORD, 16'h0d89};
        rows[3] = '{1'b0, `PFL_CMD_MODE, 32'h0, `PFL_LEN_BYTE, {8'h00, `PFL_MODE_RST}};
        rows[4] = '{1'b0, `PFL_CMD_CLRFLT, 32'h0, `PFL_LEN_NONE, `PFL_ALL_ONES};
        rows[5] = '{1'b0, `PFL_CMD_IPEAK, 32'h0, `PFL_LEN_WORD, ioutMeas[15:0]};
        rows[6] = '{1'b0, `PFL_CMD_TPEAK, 32'h0, `PFL_LEN_WORD, tempMeas};
        foreach (rows[i]) begin
            if (rows[i].wr) pfl_host_model_i.issue(1'b1, rows[i].code, rows[i].data);
            else rdChk("table row", rows[i].code, rows[i].len, rows[i].exp);
        end
        // Fault latches, alert waits for a won arbitration, clear only by command
        @(negedge clk_sys) ovFlt = 2'b01;
        @(negedge clk_sys) ovFlt = 2'b00;
        repeat (2) @(negedge clk_sys);
        chk("alert raised", 32'h1, {31'h0, alertOe});
        pfl_host_model_i.araCycle(1'b0, ack);
        chk("ara lost alert", 32'h1, {31'h0, alertOe});
        chk("ara lost ack", 32'h0, {31'h0, ack});
        pfl_host_model_i.idleGap = 3;
        pfl_host_model_i.araCycle(1'b1, ack);
        chk("ara ack", 32'h1, {31'h0, ack});
        chk("alert released", 32'h0, {31'h0, alertOe});
        pfl_host_model_i.readCmd(`PFL_CMD_VSTAT, v, d, n);
        chk("status held", 32'h1, {31'h0, d[`PFL_ST_OV]});
        pfl_host_model_i.issue(1'b1, `PFL_CMD_CLRFLT, 32'h0);
        pfl_host_model_i.idleGap = 0;
        pfl_host_model_i.readCmd(`PFL_CMD_VSTAT, v, d, n);
        chk("status cleared", 32'h0, {31'h0, d[`PFL_ST_OV]});
        // Pre-enable check for each reaction code; undervoltage never blocks
        for (int c = 0; c < 3; c++) begin
            pfl_host_model_i.issue(1'b1, `PFL_CMD_POWER, 32'h0);
            pfl_host_model_i.issue(1'b1, `PFL_CMD_REACT, {23'h0, 1'b1, 6'h00, c[1:0]});
            ovFlt = 2'b01;
            uvFlt = 2'b01;
            pfl_host_model_i.issue(1'b1, `PFL_CMD_POWER, 32'h80);
            repeat (6) @(negedge clk_sys);
            chk("enable held by check", {31'h0, c == 0}, {31'h0, supplyEn[0]});
            {ovFlt, uvFlt} = 4'h0;
            waitEn(1'b1);
        end
        // Latch-off: stays off after fault goes, restarts after off then on
        pfl_host_model_i.issue(1'b1, `PFL_CMD_REACT, {23'h0, 1'b1, 4'h0, `PFL_RESP_LATCH, 2'b00});
        ocFlt = 2'b01;
        repeat (2) @(negedge clk_sys);
        ocFlt = 2'b00;
        repeat (4) @(negedge clk_sys);
        chk("latched off", 32'h0, {31'h0, supplyEn[0]});
        chk("fault pin", 32'h1, {31'h0, faultPinOe});
        pfl_host_model_i.issue(1'b1, `PFL_CMD_CLRFLT, 32'h0);
        repeat (4) @(negedge clk_sys);
        chk("clear no restart", 32'h0, {31'h0, supplyEn[0]});
        pfl_host_model_i.issue(1'b1, `PFL_CMD_POWER, 32'h0);
        @(negedge clk_sys); // Let one edge see the on request low
        groupSwitchPin0 = 1'b1;
        waitEn(1'b1);
        rdChk("reads while on", `PFL_CMD_VOUTRD, `PFL_LEN_WORD, 16'h0d89);
        // Lock: protected reads give ones, writes dropped, key unlocks
        pfl_host_model_i.issue(1'b1, `PFL_CMD_MODE, 32'h03);
        rdChk("locked margin", `PFL_CMD_UPMARGIN, `PFL_LEN_WORD, `PFL_ALL_ONES);
        rdChk("locked mode", `PFL_CMD_MODE, `PFL_LEN_BYTE, 16'h00ff);
        pfl_host_model_i.issue(1'b1, `PFL_CMD_UPMARGIN, 32'h0000_1234);
        pfl_host_model_i.issue(1'b1, `PFL_CMD_KEY, 32'h5a3c_96e0);
        pfl_host_model_i.readCmd(`PFL_CMD_VSTAT, v, d, n);
        chk("lock flag set", 32'h1, {31'h0, d[`PFL_VSTAT_LOCK]});
        pfl_host_model_i.issue(1'b1, `PFL_CMD_KEY, 32'h5a3c_96e1);
        pfl_host_model_i.readCmd(`PFL_CMD_VSTAT, v, d, n);
        chk("lock flag clear", 32'h0, {31'h0, d[`PFL_VSTAT_LOCK]});
        rdChk("write dropped", `PFL_CMD_UPMARGIN, `PFL_LEN_WORD, 16'h0d89);
        // Soft reset clears latched status and turns the supplies off
        @(negedge clk_sys) otFlt = 2'b01;
        @(negedge clk_sys) otFlt = 2'b00;
        softRst = 1'b1;
        @(negedge clk_sys) softRst = 1'b0;
        chk("soft reset enable", 32'h0, {31'h0, supplyEn[0]});
        repeat (2) @(negedge clk_sys);
        chk("soft reset alert", 32'h0, {31'h0, alertOe});
        pfl_host_model_i.readCmd(`PFL_CMD_VSTAT, v, d, n);
        chk("soft reset status", 32'h0, {28'h0, d[3:0]});
        giveVerdict();
    end
endmodule // tb_pmbus_fault_lock_layer
